// file: verilog/evt_timer_pfd.v
// 8-bit and 16-bit event/pulse width timers with frequency divider
//
// Contract
// - event mode counts pin edges, no prescaler
// - run bit 4 starts and stops
// - edge bit 0 counts rising edges
// - edge bit 1 counts falling edges
// - overflow raises request, reloads, continues
// - interrupt enable zero suppresses interrupt
// - event counting in power-down wakes device
// - mode bits 7,6 both one: pulse mode
// - pulse clocks: prescaled, slow osc, sys/4
// - prescale bits 2..0 set 8-bit ratio
// - pulse mode run only arms counter
// - edge zero: falling start, rising stops
// - edge one: rising start, falling stops
// - hardware clears run only pulse mode
// - residual held, single shot until rerun
// - pulse mode edge driven, overflow reloads
// - divider output toggles on overflow
// - option picks source timer overflow
// - option routes divider onto line 3
// - direction and data bit gate output
// - one filter option for all pins
// - preload write loads stopped counter
`timescale 1ns/1ps
module evt_timer_pfd (
   input wire core_clk,
   input wire rst,
   input wire [7:0] ctrl0_wdata,
   input wire ctrl0_we,
   input wire [7:0] ctrl1_wdata,
   input wire ctrl1_we,
   input wire [7:0] preload0_wdata,
   input wire preload0_we,
   input wire [15:0] preload1_wdata,
   input wire preload1_we,
   input wire timer_pin0,
   input wire timer_pin1,
   input wire low_speed_internal_osc,
   input wire clk1_sel_slow,
   input wire int_enable0,
   input wire int_enable1,
   input wire power_down,
   input wire filter_enable_opt,
   input wire pfd_source_opt,
   input wire pfd_select_opt,
   input wire port_a_direction,
   input wire port_a_line3,
   input wire [7:0] intr_pin_raw,
   output reg [7:0] ctrl0,
   output reg [7:0] ctrl1,
   output reg [7:0] count0,
   output reg [15:0] count1,
   output reg irq0,
   output reg irq1,
   output reg wake,
   output reg freq_divider_output,
   output reg line3_out,
   output reg line3_oe,
   output reg [7:0] intr_pin_filt
);
`include "evt_map.vh"
////////////////////////////////////////////////////////////////////////
// input conditioning
wire lvl0;
wire lvl1;
wire lvl_osc;
wire [7:0] intr_lvl;
evt_filter u_f0 (
   .core_clk(core_clk),
   .rst(rst),
   .pin(timer_pin0),
   .filter_on(filter_enable_opt),
   .level(lvl0)
);
evt_filter u_f1 (
   .core_clk(core_clk),
   .rst(rst),
   .pin(timer_pin1),
   .filter_on(filter_enable_opt),
   .level(lvl1)
);
evt_filter u_fo (
   .core_clk(core_clk),
   .rst(rst),
   .pin(low_speed_internal_osc),
   .filter_on(1'b0),
   .level(lvl_osc)
);
genvar gi;
generate
   for (gi = 0; gi < 8; gi = gi + 1) begin : g_intr
      evt_filter u_fi (
         .core_clk(core_clk),
         .rst(rst),
         .pin(intr_pin_raw[gi]),
         .filter_on(filter_enable_opt),
         .level(intr_lvl[gi])
      );
   end
endgenerate
////////////////////////////////////////////////////////////////////////
// edge detection
reg lvl0_d;
reg lvl1_d;
reg osc_d;
always @(posedge core_clk or posedge rst) begin
   if (rst) begin
      lvl0_d <= 1'b0;
      lvl1_d <= 1'b0;
      osc_d <= 1'b0;
      intr_pin_filt <= 8'h00;
   end else begin
      lvl0_d <= lvl0;
      lvl1_d <= lvl1;
      osc_d <= lvl_osc;
      intr_pin_filt <= intr_lvl;
   end
end
wire rise0 = lvl0 & ~lvl0_d;
wire fall0 = ~lvl0 & lvl0_d;
wire rise1 = lvl1 & ~lvl1_d;
wire fall1 = ~lvl1 & lvl1_d;
wire osc_tick = lvl_osc & ~osc_d;
////////////////////////////////////////////////////////////////////////
// clock sources
reg [7:0] psc;
reg [1:0] div4;
always @(posedge core_clk or posedge rst) begin
   if (rst) begin
      psc <= 8'h00;
      div4 <= 2'h0;
   end else begin
      psc <= psc + 8'h01;
      div4 <= div4 + 2'h1;
   end
end
// ratio 2^(n+1) from rate bits
wire [2:0] rate0 = ctrl0[`EVT_PSC_HI:`EVT_PSC_LO];
wire [7:0] psc_mask = (8'h02 << rate0) - 8'h01;
wire tick0_int = ((psc & psc_mask) == psc_mask);
wire tick1_int = clk1_sel_slow ? osc_tick : (div4 == 2'h3);
////////////////////////////////////////////////////////////////////////
// per-timer decode
wire [1:0] mode0 = ctrl0[`EVT_MODE_HI:`EVT_MODE_LO];
wire [1:0] mode1 = ctrl1[`EVT_MODE_HI:`EVT_MODE_LO];
wire run0 = ctrl0[`EVT_RUN_BIT];
wire run1 = ctrl1[`EVT_RUN_BIT];
wire edg0 = ctrl0[`EVT_EDGE_BIT];
wire edg1 = ctrl1[`EVT_EDGE_BIT];
wire act0 = edg0 ? fall0 : rise0;
wire act1 = edg1 ? fall1 : rise1;
wire pwm0 = (mode0 == `EVT_MODE_PWM);
wire pwm1 = (mode1 == `EVT_MODE_PWM);
wire start0 = edg0 ? rise0 : fall0;
wire start1 = edg1 ? rise1 : fall1;
wire stop0 = edg0 ? fall0 : rise0;
wire stop1 = edg1 ? fall1 : rise1;
reg meas0;
reg meas1;
wire inc0 = run0 & ((mode0 == `EVT_MODE_EVENT) ? act0 :
   (mode0 == `EVT_MODE_TIMER) ? tick0_int : (pwm0 & meas0 & tick0_int));
wire inc1 = run1 & ((mode1 == `EVT_MODE_EVENT) ? act1 :
   (mode1 == `EVT_MODE_TIMER) ? tick1_int : (pwm1 & meas1 & tick1_int));
wire ovf0 = inc0 & (count0 == 8'hff);
wire ovf1 = inc1 & (count1 == 16'hffff);
wire end0 = pwm0 & run0 & meas0 & stop0;
wire end1 = pwm1 & run1 & meas1 & stop1;
////////////////////////////////////////////////////////////////////////
// 8-bit timer
reg [7:0] preload0;
always @(posedge core_clk or posedge rst) begin
   if (rst) begin
      ctrl0 <= `EVT_CTRL_RST;
      preload0 <= 8'h00;
      count0 <= 8'h00;
      meas0 <= 1'b0;
   end else begin
      if (ctrl0_we) begin
         ctrl0 <= ctrl0_wdata;
      end else if (end0) begin
         ctrl0[`EVT_RUN_BIT] <= 1'b0;
      end
      if (ctrl0_we || !run0 || !pwm0) begin
         meas0 <= 1'b0;
      end else if (end0) begin
         meas0 <= 1'b0;
      end else if (start0) begin
         meas0 <= 1'b1;
      end
      if (preload0_we) begin
         preload0 <= preload0_wdata;
      end
      if (preload0_we && !run0) begin
         count0 <= preload0_wdata;
      end else if (ovf0) begin
         count0 <= preload0;
      end else if (inc0) begin
         count0 <= count0 + 8'h01;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// 16-bit timer
reg [15:0] preload1;
always @(posedge core_clk or posedge rst) begin
   if (rst) begin
      ctrl1 <= `EVT_CTRL_RST;
      preload1 <= 16'h0000;
      count1 <= 16'h0000;
      meas1 <= 1'b0;
   end else begin
      if (ctrl1_we) begin
         ctrl1 <= ctrl1_wdata;
      end else if (end1) begin
         ctrl1[`EVT_RUN_BIT] <= 1'b0;
      end
      if (ctrl1_we || !run1 || !pwm1) begin
         meas1 <= 1'b0;
      end else if (end1) begin
         meas1 <= 1'b0;
      end else if (start1) begin
         meas1 <= 1'b1;
      end
      if (preload1_we) begin
         preload1 <= preload1_wdata;
      end
      if (preload1_we && !run1) begin
         count1 <= preload1_wdata;
      end else if (ovf1) begin
         count1 <= preload1;
      end else if (inc1) begin
         count1 <= count1 + 16'h0001;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// interrupts, wake-up and frequency divider
wire pfd_ovf = pfd_source_opt ? ovf1 : ovf0;
wire pfd_gate = pfd_select_opt & port_a_direction;
always @(posedge core_clk or posedge rst) begin
   if (rst) begin
      irq0 <= 1'b0;
      irq1 <= 1'b0;
      wake <= 1'b0;
      freq_divider_output <= 1'b0;
      line3_out <= 1'b0;
      line3_oe <= 1'b0;
   end else begin
      irq0 <= ovf0 & int_enable0;
      irq1 <= ovf1 & int_enable1;
      wake <= power_down & (ovf0 | ovf1);
      if (pfd_ovf) begin
         freq_divider_output <= ~freq_divider_output;
      end
      line3_oe <= port_a_direction;
      if (pfd_gate) begin
         line3_out <= port_a_line3 & (pfd_ovf ^ freq_divider_output);
      end else begin
         line3_out <= port_a_line3;
      end
   end
end
endmodule

// file: verilog/evt_map.vh
// constants for the event timer and frequency divider
`ifndef EVT_MAP_VH
`define EVT_MAP_VH
`define EVT_MODE_HI 7
`define EVT_MODE_LO 6
`define EVT_RUN_BIT 4
`define EVT_EDGE_BIT 3
`define EVT_PSC_HI 2
`define EVT_PSC_LO 0
`define EVT_MODE_TIMER 2'b10
`define EVT_MODE_EVENT 2'b01
`define EVT_MODE_PWM 2'b11
`define EVT_CTRL_RST 8'h00
`define EVT_FILT_LEN 3'h4
`endif

// file: verilog/evt_filter.v
// input synchroniser with optional noise filter
`timescale 1ns/1ps
module evt_filter (
   input wire core_clk,
   input wire rst,
   input wire pin,
   input wire filter_on,
   output reg level
);
`include "evt_map.vh"
reg s1;
reg s2;
reg s3;
reg [2:0] stable;
always @(posedge core_clk or posedge rst) begin
   if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      stable <= 3'h0;
      level <= 1'b0;
   end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 != s3) begin
         stable <= 3'h0;
      end else if (stable != `EVT_FILT_LEN) begin
         stable <= stable + 3'h1;
      end
      if (s2 == s3 && (!filter_on || stable == `EVT_FILT_LEN)) begin
         level <= s3;
      end
   end
end
endmodule

// file: sim/evt_timer_pfd_asserts.sv
// assertion checker for the event timer and divider
`timescale 1ns/1ps
module evt_timer_pfd_chk (
   input wire core_clk,
   input wire rst,
   input wire [7:0] preload0_wdata,
   input wire preload0_we,
   input wire ctrl0_we,
   input wire ctrl1_we,
   input wire int_enable0,
   input wire power_down,
   input wire pfd_select_opt,
   input wire port_a_direction,
   input wire port_a_line3,
   input wire [7:0] ctrl0,
   input wire [7:0] ctrl1,
   input wire [7:0] count0,
   input wire irq0,
   input wire wake,
   input wire line3_out
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
hw_clear0_a: assert property ($fell(ctrl0[4]) && !$past(ctrl0_we) |-> ctrl0[7:6] == 2'b11)
   else $error("run0 cleared outside pulse mode");
hw_clear1_a: assert property ($fell(ctrl1[4]) && !$past(ctrl1_we) |-> ctrl1[7:6] == 2'b11)
   else $error("run1 cleared outside pulse mode");
idle_count_a: assert property (!ctrl0[4] && !preload0_we && !ctrl0_we |=> $stable(count0))
   else $error("stopped counter moved");
preload_stop_a: assert property (preload0_we && !ctrl0[4] |=> count0 == $past(preload0_wdata))
   else $error("preload not loaded while stopped");
irq_cause_a: assert property (irq0 |-> $past(count0) == 8'hff || $past(count0, 2) == 8'hff)
   else $error("irq without overflow");
irq_mask_a: assert property ((!int_enable0) [*3] |-> !irq0)
   else $error("irq while disabled");
wake_cause_a: assert property (wake |-> $past(power_down) || $past(power_down, 2))
   else $error("wake outside power down");
line3_low_a: assert property ((pfd_select_opt && port_a_direction && !port_a_line3) [*3] |-> !line3_out)
   else $error("line3 high with data bit low");
cover property (irq0);
cover property (wake);
cover property ($fell(ctrl0[4]) && !$past(ctrl0_we));
endmodule
bind evt_timer_pfd evt_timer_pfd_chk chk (.*);

// file: sim/evt_pin_src.sv
// external logic source on the timer input pin
`timescale 1ns/1ps
module evt_pin_src (
   input wire core_clk,
   input wire run,
   input wire [7:0] half,
   output reg pin
);
reg [7:0] cnt;
initial begin
   pin = 1'b0;
   cnt = 8'h00;
end
// level stands still while not running
always @(posedge core_clk) begin
   if (!run) begin
      cnt <= 8'h00;
   end else if (cnt >= half) begin
      cnt <= 8'h00;
      pin <= ~pin;
   end else begin
      cnt <= cnt + 8'h01;
   end
end
endmodule

// file: sim/evt_timer_pfd_tb.sv
// self-checking bench for the event timer and divider
`timescale 1ns/1ps
module evt_timer_pfd_tb;
reg core_clk, rst, ctrl0_we, ctrl1_we, preload0_we, preload1_we, run, int_enable0, int_enable1;
reg power_down, filter_enable_opt, pfd_source_opt, low_speed_internal_osc, clk1_sel_slow;
reg pfd_select_opt, port_a_direction, port_a_line3;
reg [7:0] ctrl0_wdata, ctrl1_wdata, preload0_wdata, intr_pin_raw, half;
reg [15:0] preload1_wdata;
wire timer_pin0, irq0, irq1, wake, freq_divider_output, line3_out;
wire [7:0] ctrl0, ctrl1, count0;
wire [15:0] count1;
int fails, n_checks, nr, nf, ni, nw, nt, i, r, h, a, b, c, t0, ed, ov;
logic [7:0] p;
logic e;
logic [15:0] m, got;
logic [23:0] qe;
logic [23:0] q[$];
event shot;
evt_timer_pfd uut (.*, .timer_pin1(timer_pin0), .line3_oe(), .intr_pin_filt());
evt_pin_src src (.core_clk(core_clk), .run(run), .half(half), .pin(timer_pin0));
initial begin
   core_clk = 1'b0;
   forever #12.5 core_clk = ~core_clk;
end
always @(posedge timer_pin0) nr++;
always @(negedge timer_pin0) nf++;
always @(posedge irq0) ni++;
always @(posedge wake) nw++;
always @(freq_divider_output) nt++;
always @(shot) begin
   qe = q.pop_front();
   n_checks++;
   if ((got + qe[23:16] >= qe[15:0] && got <= qe[15:0] + qe[23:16]) !== 1'b1) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, qe[15:0]);
   end
end
task note(input logic [15:0] g, input logic [15:0] x, input logic [7:0] t);
   got = g;
   q.push_back({t, x});
   -> shot;
   #1;
endtask
task wr(input logic [3:0] k, input logic [15:0] d);
   @(posedge core_clk);
   {ctrl0_we, ctrl1_we, preload0_we, preload1_we} <= k;
   {ctrl0_wdata, ctrl1_wdata, preload0_wdata, preload1_wdata} <= {d[7:0], d[7:0], d[7:0], d};
   @(posedge core_clk);
   {ctrl0_we, ctrl1_we, preload0_we, preload1_we} <= 4'h0;
   @(negedge core_clk);
endtask
task go(input int n);
   @(posedge core_clk);
   run <= 1'b1;
   repeat (n) @(posedge core_clk);
   run <= 1'b0;
   repeat (24) @(posedge core_clk);
   @(negedge core_clk);
endtask
task test_done;
   $display("checks %0d mismatches %0d", n_checks, fails);
   if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
   end else begin
      $display("Some tests failed");
   end
   $finish;
endtask
initial begin
   repeat (100000) @(posedge core_clk);
   fails++;
   test_done;
end
initial begin
   {rst, run, ctrl0_we, ctrl1_we, preload0_we, preload1_we, int_enable0, int_enable1} = 8'h80;
   {power_down, filter_enable_opt, pfd_source_opt, low_speed_internal_osc, clk1_sel_slow} = 5'h00;
   {pfd_select_opt, port_a_direction, port_a_line3} = 3'h7;
   {ctrl0_wdata, ctrl1_wdata, preload0_wdata, intr_pin_raw, half, preload1_wdata} = 56'h0;
   void'($urandom(86));
   repeat (8) @(posedge core_clk);
   rst <= 1'b0;
   for (i = 0; i < 4; i++) begin
      e = i[0];
      p = 8'hf0 | 8'($urandom % 16);
      half <= 8'(6 + $urandom % 4);
      intr_pin_raw <= 8'($urandom);
      {filter_enable_opt, power_down, int_enable0, port_a_line3} <= {i[1], e, i != 2, i != 2};
      wr(4'h8, {12'h004, e, 3'h0});
      wr(4'h2, {8'h00, p});
      note(count0, p, 0);
      a = e ? nf : nr;
      {b, c, t0} = {ni, nw, nt};
      wr(4'h8, {12'h005, e, 3'h0});
      go(200);
      ed = (e ? nf : nr) - a;
      ov = ed / (256 - p);
      note(count0, 16'(p + ed % (256 - p)), 0);
      note(16'(ni - b), i == 2 ? 16'h0 : 16'(ov), 0);
      note(16'(nw - c), e ? 16'(ov) : 16'h0, 0);
      note(16'(nt - t0), 16'(ov), 0);
      note(line3_out, port_a_line3 ? freq_divider_output : 1'b0, 0);
      note(uut.line3_oe, 1, 0);
      note(uut.intr_pin_filt, intr_pin_raw, 0);
      wr(4'h8, 16'h0040);
      $display("event test %0d done", i);
   end
   for (i = 0; i < 4; i++) begin
      r = $urandom % 3;
      h = 40 + $urandom % 60;
      half <= 8'(h);
      m = {8'h00, 4'hc, i[0], 3'(r)};
      wr(4'hc, m);
      wr(4'h3, 16'h0000);
      wr(4'hc, m | 16'h0010);
      go(8 * (h + 1));
      note(ctrl0[4], 0, 0);
      note(ctrl1[4], 0, 0);
      note(count0, 16'((h + 1) >> (r + 1)), 2);
      note(count1, 16'((h + 1) >> 2), 2);
      $display("pulse test %0d done", i);
   end
   test_done;
end
endmodule
